// File: jtag_pkg.sv
// shared constants and types of the boundary-scan test access port
package jtag_pkg;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int IR_LEN = 4;
  localparam logic [IR_LEN-1:0] INSTR_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] INSTR_IDCODE = 4'h2;
  localparam logic [IR_LEN-1:0] INSTR_BYPASS = 4'hf;
  // low two bits fixed at 01 so a broken chain is visible on capture
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [IR_LEN-1:0] IR_RESET_VAL = INSTR_IDCODE;

  // ----------------------------------------------------------------
  // data registers and pins
  // ----------------------------------------------------------------
  localparam int ID_LEN = 32;
  localparam int BSR_LEN_DEF = 8;
  // undriven test pins read high through their pull-ups
  localparam logic PIN_IDLE_VAL = 1'b1;
  // the test clock has no pull-up and idles low between frames
  localparam logic TCK_IDLE_VAL = 1'b0;
  localparam logic TDO_RESET_VAL = 1'b0;
  // consecutive high mode-select edges that always reach reset
  localparam int TLR_TMS_COUNT = 5;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR     = 4'b1111,
    RTI     = 4'b1100,
    SEL_DR  = 4'b0111,
    CAP_DR  = 4'b0110,
    SH_DR   = 4'b0010,
    EX1_DR  = 4'b0001,
    PAU_DR  = 4'b0011,
    EX2_DR  = 4'b0000,
    UPD_DR  = 4'b0101,
    SEL_IR  = 4'b0100,
    CAP_IR  = 4'b1110,
    SH_IR   = 4'b1010,
    EX1_IR  = 4'b1001,
    PAU_IR  = 4'b1011,
    EX2_IR  = 4'b1000,
    UPD_IR  = 4'b1101
  } tap_state_t;

endpackage

// File: jtag_scan_chain.sv
// boundary-scan cell chain with capture, shift and update stages
`timescale 1ns/10ps
module jtag_scan_chain #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic arst_i,
  input wire logic ce_i,
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  input wire logic si_i,
  input wire logic [WIDTH-1:0] par_i,
  output logic so_o,
  output logic [WIDTH-1:0] par_o
);
  import jtag_pkg::*;

  logic [WIDTH-1:0] sr_reg;
  logic [WIDTH-1:0] sr_next;

  assign sr_next = capture_i ? par_i : (shift_i ? {si_i, sr_reg[WIDTH-1:1]} : sr_reg);
  assign so_o = sr_reg[0];

  always_ff @(posedge clk_i or posedge arst_i) begin
    if (arst_i) begin
      sr_reg <= '0;
      par_o <= '0;
    end else if (ce_i) begin
      sr_reg <= sr_next;
      if (update_i) begin
        par_o <= sr_reg;
      end
    end
  end

  a_chain_shift_in: assert property (@(posedge clk_i) disable iff (arst_i)
    ce_i && shift_i && !capture_i |=> sr_reg == {$past(si_i), $past(sr_reg[WIDTH-1:1])})
    else $error("scan chain did not shift one place");

  a_chain_update_out: assert property (@(posedge clk_i) disable iff (arst_i)
    ce_i && update_i |=> par_o == $past(sr_reg))
    else $error("scan chain update lost");

endmodule

// File: jtag_test_access_port.sv
// boundary-scan test access port sampled by the system clock
//
// Functional notes
// - a low test reset forces the test logic to reset without any test clock
// - mode-select and data-in synchronisers reset high; test reset has no default level
// - mode-select and data-in are taken on each rising test clock edge
// - test data out changes only on falling test clock edges
// - with the test clock stopped every state element after the pin synchronisers holds its value
// - test data out is driven only while shifting, high impedance otherwise
// - instructions and data both enter through data-in, chosen by controller state
`timescale 1ns/10ps
module jtag_test_access_port #(
  parameter int BSR_LEN = jtag_pkg::BSR_LEN_DEF,
  parameter logic [jtag_pkg::ID_LEN-1:0] IDCODE_VALUE = 32'h00000001 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic trst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [BSR_LEN-1:0] pins_i,
  output logic [BSR_LEN-1:0] pins_o,
  output logic extest_o,
  output logic tdo_o,
  output logic tdo_oe_n_o
);
  import jtag_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic tck_d_reg;
  logic rst_hold_reg;
  logic rst_hold2_reg;
  wire trst_req = reset_i | ~trst_n_i;
  wire tap_arst = trst_req | rst_hold2_reg;

  assign pin_raw = {tck_i, tms_i, tdi_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      // tck resets to its idle low level, else a false edge would follow reset
      localparam logic SYNC_IDLE = (g == 2) ? TCK_IDLE_VAL : PIN_IDLE_VAL;
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          sync1_reg[g] <= SYNC_IDLE;
          sync2_reg[g] <= SYNC_IDLE;
        end else if (ce_i) begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  wire tck_s = sync2_reg[2];
  wire tms_s = sync2_reg[1];
  wire tdi_s = sync2_reg[0];

  // test reset asserts at once but releases on the clock, so the
  // controller never leaves reset on a half-seen release
  always_ff @(posedge clk_i or posedge trst_req) begin
    if (trst_req) begin
      rst_hold_reg <= 1'b1;
      rst_hold2_reg <= 1'b1;
    end else if (ce_i) begin
      rst_hold_reg <= 1'b0;
      rst_hold2_reg <= rst_hold_reg;
    end
  end

  // ----------------------------------------------------------------
  // test clock edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tck_d_reg <= 1'b0;
    end else if (ce_i) begin
      tck_d_reg <= tck_s;
    end
  end

  // no edge, no step: a stopped test clock freezes the logic below
  wire tck_rise = ce_i & tck_s & ~tck_d_reg;
  wire tck_fall = ce_i & ~tck_s & tck_d_reg;

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  tap_state_t state_reg;
  tap_state_t state_next;

  always_comb begin
    case (state_reg)
      TLR: state_next = tms_s ? TLR : RTI;
      RTI: state_next = tms_s ? SEL_DR : RTI;
      SEL_DR: state_next = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: state_next = tms_s ? EX1_DR : SH_DR;
      SH_DR: state_next = tms_s ? EX1_DR : SH_DR;
      EX1_DR: state_next = tms_s ? UPD_DR : PAU_DR;
      PAU_DR: state_next = tms_s ? EX2_DR : PAU_DR;
      EX2_DR: state_next = tms_s ? UPD_DR : SH_DR;
      UPD_DR: state_next = tms_s ? SEL_DR : RTI;
      SEL_IR: state_next = tms_s ? TLR : CAP_IR;
      CAP_IR: state_next = tms_s ? EX1_IR : SH_IR;
      SH_IR: state_next = tms_s ? EX1_IR : SH_IR;
      EX1_IR: state_next = tms_s ? UPD_IR : PAU_IR;
      PAU_IR: state_next = tms_s ? EX2_IR : PAU_IR;
      EX2_IR: state_next = tms_s ? UPD_IR : SH_IR;
      UPD_IR: state_next = tms_s ? SEL_DR : RTI;
      default: state_next = TLR;
    endcase
  end

  always_ff @(posedge clk_i or posedge tap_arst) begin
    if (tap_arst) begin
      state_reg <= TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [IR_LEN-1:0] ir_sr_reg;
  logic [IR_LEN-1:0] ir_reg;
  wire in_sh_ir = state_reg == SH_IR;
  wire in_sh_dr = state_reg == SH_DR;
  wire ir_cap = tck_rise & (state_reg == CAP_IR);
  wire ir_shift = tck_rise & in_sh_ir;
  wire dr_cap = tck_rise & (state_reg == CAP_DR);
  wire dr_shift = tck_rise & in_sh_dr;
  wire dr_upd = tck_fall & (state_reg == UPD_DR);

  always_ff @(posedge clk_i or posedge tap_arst) begin
    if (tap_arst) begin
      ir_sr_reg <= IR_CAPTURE_VAL;
      ir_reg <= IR_RESET_VAL;
    end else begin
      if (ir_cap) begin
        ir_sr_reg <= IR_CAPTURE_VAL;
      end else if (ir_shift) begin
        ir_sr_reg <= {tdi_s, ir_sr_reg[IR_LEN-1:1]};
      end
      // the instruction falls back on the first falling edge spent in reset
      if (tck_fall && state_reg == TLR) begin
        ir_reg <= IR_RESET_VAL;
      end else if (tck_fall && state_reg == UPD_IR) begin
        ir_reg <= ir_sr_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  wire sel_bsr = (ir_reg == INSTR_EXTEST) | (ir_reg == INSTR_SAMPLE);
  wire sel_id = ir_reg == INSTR_IDCODE;
  logic bypass_reg;
  logic [ID_LEN-1:0] id_sr_reg;
  logic bsr_so;

  always_ff @(posedge clk_i or posedge tap_arst) begin
    if (tap_arst) begin
      bypass_reg <= 1'b0;
      id_sr_reg <= '0;
      extest_o <= 1'b0;
    end else begin
      if (dr_cap) begin
        bypass_reg <= 1'b0;
        id_sr_reg <= IDCODE_VALUE;
      end else if (dr_shift) begin
        bypass_reg <= tdi_s;
        id_sr_reg <= {tdi_s, id_sr_reg[ID_LEN-1:1]};
      end
      if (ce_i) begin
        extest_o <= ir_reg == INSTR_EXTEST;
      end
    end
  end

  jtag_scan_chain #(
    .WIDTH(BSR_LEN)
  ) u_bsr (
    .clk_i(clk_i),
    .arst_i(tap_arst),
    .ce_i(ce_i),
    .capture_i(dr_cap & sel_bsr),
    .shift_i(dr_shift & sel_bsr),
    .update_i(dr_upd & sel_bsr),
    .si_i(tdi_s),
    .par_i(pins_i),
    .so_o(bsr_so),
    .par_o(pins_o)
  );

  wire dr_so = sel_bsr ? bsr_so : (sel_id ? id_sr_reg[0] : bypass_reg);
  wire tdo_next = in_sh_ir ? ir_sr_reg[0] : dr_so;

  // ----------------------------------------------------------------
  // test data out, launched on the falling edge only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge tap_arst) begin
    if (tap_arst) begin
      tdo_o <= TDO_RESET_VAL;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_o <= tdo_next;
      tdo_oe_n_o <= ~(in_sh_ir | in_sh_dr);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] tms_run_reg;
  always_ff @(posedge clk_i or posedge tap_arst) begin
    if (tap_arst) begin
      tms_run_reg <= 3'h0;
    end else if (tck_rise) begin
      tms_run_reg <= !tms_s ? 3'h0 : (tms_run_reg == 3'h7 ? 3'h7 : tms_run_reg + 3'h1);
    end
  end

  a_trst_forces_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    !trst_n_i |-> state_reg == TLR && tdo_oe_n_o)
    else $error("test reset did not hold the controller in reset");

  a_five_tms_reset: assert property (@(posedge clk_i) disable iff (tap_arst)
    tms_run_reg >= 3'(TLR_TMS_COUNT) |-> state_reg == TLR)
    else $error("five high mode-select edges did not reach reset");

  a_state_hold_idle: assert property (@(posedge clk_i) disable iff (tap_arst)
    !tck_rise && !tck_fall |=> $stable(state_reg) && $stable(ir_reg) && $stable(tdo_o))
    else $error("test logic changed without a test clock edge");

  a_tdo_on_fall: assert property (@(posedge clk_i) disable iff (tap_arst)
    $changed(tdo_o) || $changed(tdo_oe_n_o) |-> $past(tck_fall))
    else $error("test data out changed off a falling edge");

  a_oe_only_shift: assert property (@(posedge clk_i) disable iff (tap_arst)
    !tdo_oe_n_o |-> state_reg inside {SH_IR, SH_DR, EX1_IR, EX1_DR})
    else $error("test data out driven outside a shift");

  a_state_on_rise: assert property (@(posedge clk_i) disable iff (tap_arst)
    tck_rise |=> state_reg == $past(state_next))
    else $error("controller did not follow mode-select on a rising edge");

  a_ir_capture_val: assert property (@(posedge clk_i) disable iff (tap_arst)
    ir_cap |=> ir_sr_reg == IR_CAPTURE_VAL ##1 state_reg != CAP_IR)
    else $error("instruction capture value wrong");

  a_ir_shift_in: assert property (@(posedge clk_i) disable iff (tap_arst)
    ir_shift |=> ir_sr_reg == {$past(tdi_s), $past(ir_sr_reg[IR_LEN-1:1])})
    else $error("instruction shift lost a bit");

  a_idle_pins_high: assert property (@(posedge clk_i)
    reset_i |=> tms_s && tdi_s)
    else $error("idle test inputs did not read high after reset");

endmodule

// File: jtag_ctl_model.sv
// behavioural boundary-scan controller that drives the test port link
`timescale 1ns/10ps
module jtag_ctl_model (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // tck stands low between frames; tms and tdi move only while tck is low
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b0;
  end

  // one tck period of 64 ns; tdo is taken at the rising edge
  // non-blocking, so a change that lands on a system clock edge is seen after it
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    #32;
    tck_o <= 1'b1;
    tdo = tdo_i;
    #32;
    tck_o <= 1'b0;
  endtask

  task automatic hold_reset();
    tms_o <= 1'b1;
    @(posedge clk_i);
    trst_n_o <= 1'b0;
  endtask

  task automatic release_reset();
    tms_o <= 1'b1;
    @(posedge clk_i);
    trst_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  // from idle: select, capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din, input int pause,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (is_ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      if (i == pause) #1000;
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule

// File: jtag_test_access_port_tb.sv
// self-checking bench of the boundary-scan test access port
`timescale 1ns/10ps
module jtag_test_access_port_tb;
  import jtag_pkg::*;
  localparam int BSR = 8;
  localparam logic [ID_LEN-1:0] ID_VAL = 32'h5a3c0001; // arbitrary value
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic [BSR-1:0] pins_in = 8'h00;
  logic [BSR-1:0] pins_out, last_pins;
  logic extest, tdo, tdo_oe_n, tck, tms, tdi, trst_n;
  wire logic tdo_w;
  logic [15:0] rnd = 16'ha6cb;
  logic [IR_LEN-1:0] ops [4] = '{INSTR_SAMPLE, 4'h7, INSTR_BYPASS, INSTR_EXTEST};
  int mismatches = 0, tests_run = 0;

  // a released tdo reads as z so a bit taken while not driving never matches
  assign tdo_w = tdo_oe_n ? 1'bz : tdo;

  initial begin
    forever #2.5 clk = ~clk;
  end

  jtag_test_access_port #(.BSR_LEN(BSR), .IDCODE_VALUE(ID_VAL)) jtag_test_access_port_i (
    .clk_i(clk), .reset_i(reset), .ce_i(ce), .trst_n_i(trst_n), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .pins_i(pins_in), .pins_o(pins_out), .extest_o(extest), .tdo_o(tdo),
    .tdo_oe_n_o(tdo_oe_n));

  jtag_ctl_model jtag_ctl_model_i (
    .clk_i(clk), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // chain instructions capture the pins, all others give a one-bit bypass delay
  function automatic logic [31:0] exp_dr(input logic [IR_LEN-1:0] op, input logic [7:0] p,
                                         input logic [7:0] v);
    return (op == INSTR_SAMPLE || op == INSTR_EXTEST) ? {24'h0, p} : {24'h0, v[6:0], 1'b0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(tdo or tdo_oe_n) begin
    if ($time > 0 && trst_n === 1'b1) check({31'h0, tck}, 32'h0);
  end

  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] got;
    logic b;
    last_pins = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    jtag_ctl_model_i.release_reset();
    check({22'h0, pins_out, extest, tdo_oe_n}, {22'h0, 8'h00, 1'b0, 1'b1});
    jtag_ctl_model_i.step(1'b0, 1'b1, b);
    jtag_ctl_model_i.scan(1'b0, ID_LEN, 32'hffffffff, 13, got);
    check(got, ID_VAL);
    check({31'h0, tdo_oe_n}, 32'h1);
    $display("test identification read done");
    foreach (ops[k]) begin
      rnd = lfsr_next(rnd);
      @(posedge clk);
      pins_in <= rnd[15:8];
      jtag_ctl_model_i.scan(1'b1, IR_LEN, {28'h0, ops[k]}, -1, got);
      check(got, {28'h0, IR_CAPTURE_VAL});
      rnd = lfsr_next(rnd);
      jtag_ctl_model_i.scan(1'b0, BSR, {24'h0, rnd[7:0]}, -1, got);
      check(got, exp_dr(ops[k], pins_in, rnd[7:0]));
      if (ops[k] == INSTR_SAMPLE || ops[k] == INSTR_EXTEST) last_pins = rnd[7:0];
      repeat (4) @(posedge clk);
      check({23'h0, pins_out, extest}, {23'h0, last_pins, ops[k] == INSTR_EXTEST});
      $display("test instruction %h done", ops[k]);
    end
    // a whole test clock pulse while the clock enable is low must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    jtag_ctl_model_i.step(1'b1, 1'b1, b);
    @(posedge clk);
    ce <= 1'b1;
    jtag_ctl_model_i.scan(1'b0, BSR, {24'h0, ~pins_in}, -1, got);
    check(got, {24'h0, pins_in});
    check({31'h0, extest}, 32'h1);
    $display("test clock enable freeze done");
    // reach reset from a data shift right after entering it
    jtag_ctl_model_i.step(1'b1, 1'b1, b);
    jtag_ctl_model_i.step(1'b0, 1'b1, b);
    jtag_ctl_model_i.step(1'b0, 1'b1, b);
    for (int i = 0; i < TLR_TMS_COUNT; i++) jtag_ctl_model_i.step(1'b1, 1'b0, b);
    repeat (8) @(posedge clk);
    check({31'h0, extest}, 32'h0);
    jtag_ctl_model_i.step(1'b0, 1'b1, b);
    jtag_ctl_model_i.scan(1'b0, ID_LEN, 32'h0, -1, got);
    check(got, ID_VAL);
    jtag_ctl_model_i.scan(1'b1, IR_LEN, {28'h0, INSTR_EXTEST}, -1, got);
    repeat (4) @(posedge clk);
    check({31'h0, extest}, 32'h1);
    $display("test five high mode-selects done");
    jtag_ctl_model_i.hold_reset();
    repeat (2) @(posedge clk);
    check({22'h0, pins_out, extest, tdo_oe_n}, {22'h0, 8'h00, 1'b0, 1'b1});
    jtag_ctl_model_i.release_reset();
    jtag_ctl_model_i.step(1'b0, 1'b1, b);
    jtag_ctl_model_i.scan(1'b0, ID_LEN, 32'h0, -1, got);
    check(got, ID_VAL);
    $display("test asynchronous test reset done");
    give_verdict();
  end
endmodule
